/* inc/sercb_pkg.sv */
// Constants and carriers for the serial control and baud block.
// Assumes one clock domain and the plain register port of the host CPU.
package sercb_pkg;
   // ==========================================================
   // Register indices (byte offsets on the plain register port)
   localparam logic [2:0] ADDR_STATUS = 3'h0;
   localparam logic [2:0] ADDR_DATA = 3'h1;
   localparam logic [2:0] ADDR_BAUD = 3'h2;
   localparam logic [2:0] ADDR_CTRL1 = 3'h3;
   localparam logic [2:0] ADDR_CTRL2 = 3'h4;
   localparam logic [2:0] ADDR_RXEXT = 3'h5;
   localparam logic [2:0] ADDR_TXEXT = 3'h7;
   // ==========================================================
   // Control two field positions
   localparam int CR2_TXEIE = 7;
   localparam int CR2_XMIT_DONE_IRQ_ON = 6;
   localparam int CR2_RXIE = 5;
   localparam int CR2_IDIE = 4;
   localparam int CR2_TXON = 3;
   localparam int CR2_RXON = 2;
   localparam int CR2_MUTE = 1;
   localparam int CR2_BRK = 0;
   // Baud register fields
   localparam int BRR_PRE_LO = 6;
   localparam int BRR_TX_LO = 3;
   localparam int BRR_RX_LO = 0;
   // Control one: word length and wake method
   localparam int CR1_LONG = 4;
   localparam int CR1_WAKE = 3;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_BAUD = 8'h00;
   localparam logic [7:0] RST_EXT = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'hC0;
   // Prescaler factors for first_prescale codes
   localparam logic [3:0] PRE_F0 = 4'h1;
   localparam logic [3:0] PRE_F1 = 4'h3;
   localparam logic [3:0] PRE_F2 = 4'h4;
   localparam logic [3:0] PRE_F3 = 4'hD;
   localparam logic [3:0] OVERSAMPLE = 4'hF;
   localparam logic [3:0] OVS_MID = 4'h7;
   // ==========================================================
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sercb_bus_t;
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} sercb_tx_t;
   typedef enum {RX_HUNT, RX_START, RX_DATA, RX_STOP} sercb_rx_t;
endpackage

/* rtl/sercb_core.sv */
// Serial control, data buffer and baud generators of an async serial port.
// Assumes one 200 MHz clock, a remote transceiver on txdOut and rxdIn.
import sercb_pkg::*;

module sercb_core (
   input wire logic clk,
   input wire logic resetn,
   input wire sercb_bus_t busIn,
   output logic [7:0] rdData,
   output logic txdOut,
   output logic txdOe_n,
   input wire logic rxdIn,
   output logic irqReq
);
   // ==========================================================
   // Registers
   logic [7:0] ctrl2_r, baud_r, rxExt_r, txExt_r, ctrl1_r;
   logic [7:0] txBuf_r, rxBuf_r, rdData_r;
   logic txEmpty_r, txDone_r, rxFull_r, idle_r, overrun_r, frameErr_r;
   logic statusSeen_r, txEverOn_r, txOnPrev_r, brkPrev_r;
   logic preamblePend_r, brkPend_r;
   logic rxSync1_r, rxSync2_r;

   wire wrData = busIn.wr && busIn.addr == ADDR_DATA;
   wire rdDataHit = busIn.rd && busIn.addr == ADDR_DATA;
   wire rdStatus = busIn.rd && busIn.addr == ADDR_STATUS;
   wire txOn = ctrl2_r[CR2_TXON];
   wire rxOn = ctrl2_r[CR2_RXON];
   wire longWord = ctrl1_r[CR1_LONG];

   // ==========================================================
   // Baud generation
   function automatic logic [3:0] preFactor(input logic [1:0] code);
      case (code)
         2'h0: preFactor = PRE_F0;
         2'h1: preFactor = PRE_F1;
         2'h2: preFactor = PRE_F2;
         default: preFactor = PRE_F3;
      endcase
   endfunction

   logic [3:0] preCnt_r;
   wire [3:0] preMax = preFactor(baud_r[BRR_PRE_LO +: 2]) - 4'h1;
   wire preTick = preCnt_r == preMax;
   // Oversample ticks (16 per bit) for tx and rx
   wire [1:0] ovsTick;
   logic [6:0] rateCnt_r [2];
   logic [7:0] extCnt_r [2];
   wire [2:0] rateField [2];
   wire [7:0] extVal [2];
   assign rateField[0] = baud_r[BRR_TX_LO +: 3];
   assign rateField[1] = baud_r[BRR_RX_LO +: 3];
   assign extVal[0] = txExt_r;
   assign extVal[1] = rxExt_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         preCnt_r <= 4'h0;
      end else begin
         preCnt_r <= preTick ? 4'h0 : preCnt_r + 4'h1;
      end
   end

   for (genvar g = 0; g < 2; g++) begin : gRate
      wire [6:0] rateMax = 7'((8'h1 << rateField[g]) - 8'h1);
      wire extMode = extVal[g] != 8'h00;
      wire convTick = preTick && rateCnt_r[g] == rateMax;
      // Extended tick every ext count; sixteen ticks make one bit
      wire extTick = extCnt_r[g] == extVal[g] - 8'h1;
      assign ovsTick[g] = extMode ? extTick : convTick;
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            rateCnt_r[g] <= 7'h00;
            extCnt_r[g] <= 8'h00;
         end else begin
            if (preTick) begin
               rateCnt_r[g] <= convTick ? 7'h00 : rateCnt_r[g] + 7'h01;
            end
            extCnt_r[g] <= extTick ? 8'h00 : extCnt_r[g] + 8'h01;
         end
      end
   end

   // ==========================================================
   // Transmitter
   sercb_tx_t txState_r;
   logic [3:0] txOvs_r, txBit_r;
   logic [8:0] txShift_r;
   logic [1:0] txKind_r; // 0 data, 1 preamble, 2 break
   logic txLine_r, txDelay_r;
   wire txBitTick = ovsTick[0] && txOvs_r == OVERSAMPLE;
   wire [3:0] lastBit = longWord ? 4'h8 : 4'h7;
   wire txRise = txOn && !txOnPrev_r;
   wire brkFall = !ctrl2_r[CR2_BRK] && brkPrev_r;
   wire needBrk = ctrl2_r[CR2_BRK] || brkPend_r;
   // No start in the enable cycle itself, so the bit-time wait always holds
   wire txStartOk = txState_r == TX_IDLE && txOn && !txRise && !txDelay_r
                    && txBitTick;
   wire startPre = txStartOk && preamblePend_r;
   wire startBrk = txStartOk && !preamblePend_r && needBrk;
   wire startData = txStartOk && !preamblePend_r && !needBrk && !txEmpty_r;
   wire txFrameEnd = txState_r == TX_STOP && txBitTick;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txState_r <= TX_IDLE;
         txOvs_r <= 4'h0;
         txBit_r <= 4'h0;
         txShift_r <= 9'h1FF;
         txKind_r <= 2'h0;
         txLine_r <= 1'b1;
         txDelay_r <= 1'b0;
      end else begin
         if (ovsTick[0]) begin
            txOvs_r <= txOvs_r + 4'h1;
         end
         if (txRise) begin
            txDelay_r <= 1'b1;
         end else if (txBitTick) begin
            txDelay_r <= 1'b0;
         end
         case (txState_r)
            TX_IDLE: begin
               txLine_r <= 1'b1;
               if (startData || startBrk || startPre) begin
                  txState_r <= TX_START;
                  txKind_r <= startPre ? 2'h1 : (startBrk ? 2'h2 : 2'h0);
                  txShift_r <= startData ? {ctrl1_r[6], txBuf_r} : 9'h000;
                  txLine_r <= startPre; // Preamble keeps the line high
               end
            end
            TX_START: if (txBitTick) begin
               txState_r <= TX_DATA;
               txBit_r <= 4'h0;
               txLine_r <= txKind_r == 2'h1 ? 1'b1 : txShift_r[0];
            end
            TX_DATA: if (txBitTick) begin
               txShift_r <= {1'b0, txShift_r[8:1]};
               if (txBit_r == lastBit) begin
                  txState_r <= TX_STOP;
                  txLine_r <= txKind_r != 2'h2; // Break holds low through stop
               end else begin
                  txBit_r <= txBit_r + 4'h1;
                  txLine_r <= txKind_r == 2'h1 ? 1'b1 : txShift_r[1];
               end
            end
            TX_STOP: if (txBitTick) begin
               txState_r <= TX_IDLE;
               txLine_r <= 1'b1;
            end
            default: txState_r <= TX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Receiver
   sercb_rx_t rxState_r;
   logic [3:0] rxOvs_r, rxBit_r, idleCnt_r;
   logic [8:0] rxShift_r;
   logic idleArmed_r;
   wire rxSample = ovsTick[1] && rxOvs_r == OVS_MID;
   wire rxWordDone = rxState_r == RX_STOP && rxSample;
   // Eight-bit words still sit one place high when the stop bit is sampled
   wire [8:0] rxWord = longWord ? rxShift_r : {1'b0, rxShift_r[8:1]};
   wire muted = ctrl2_r[CR2_MUTE];
   wire idleSeen = rxOn && rxState_r == RX_HUNT && ovsTick[1] && rxSync2_r
                   && idleCnt_r == lastBit + 4'h2 && rxOvs_r == OVERSAMPLE;
   wire addrWake = rxWordDone && ctrl1_r[CR1_WAKE] && rxWord[lastBit];
   wire wakeUp = muted && (ctrl1_r[CR1_WAKE] ? addrWake : idleSeen);
   wire rxDeliver = rxWordDone && (!muted || addrWake);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxSync1_r <= 1'b1;
         rxSync2_r <= 1'b1;
         rxState_r <= RX_HUNT;
         rxOvs_r <= 4'h0;
         rxBit_r <= 4'h0;
         rxShift_r <= 9'h000;
         idleCnt_r <= 4'h0;
      end else begin
         rxSync1_r <= rxdIn;
         rxSync2_r <= rxSync1_r;
         if (ovsTick[1]) begin
            rxOvs_r <= rxOvs_r + 4'h1;
         end
         if (ovsTick[1] && rxOvs_r == OVERSAMPLE) begin
            idleCnt_r <= !rxSync2_r ? 4'h0 : (idleCnt_r == 4'hF ? idleCnt_r : idleCnt_r + 4'h1);
         end
         case (rxState_r)
            RX_HUNT: if (rxOn && ovsTick[1] && !rxSync2_r) begin
               rxState_r <= RX_START;
               rxOvs_r <= 4'h0;
            end
            RX_START: if (rxSample) begin
               rxState_r <= rxSync2_r ? RX_HUNT : RX_DATA;
               rxBit_r <= 4'h0;
            end
            RX_DATA: if (rxSample) begin
               rxShift_r <= {rxSync2_r, rxShift_r[8:1]};
               if (rxBit_r == lastBit) begin
                  rxState_r <= RX_STOP;
               end
               rxBit_r <= rxBit_r + 4'h1;
            end
            RX_STOP: if (rxSample) begin
               rxState_r <= RX_HUNT;
            end
            default: rxState_r <= RX_HUNT;
         endcase
         if (!rxOn) begin
            rxState_r <= RX_HUNT;
         end
      end
   end

   // ==========================================================
   // Register file and status flags
   wire flagClrRx = statusSeen_r && rdDataHit;
   wire flagClrTx = statusSeen_r && wrData;
   wire txLoad = startData;
   wire [7:0] statusVal = {txEmpty_r, txDone_r, rxFull_r, idle_r, overrun_r, 1'b0,
                           frameErr_r, 1'b0};
   wire [7:0] rdMux = busIn.addr == ADDR_STATUS ? statusVal :
                      busIn.addr == ADDR_DATA ? rxBuf_r :
                      busIn.addr == ADDR_BAUD ? baud_r :
                      busIn.addr == ADDR_CTRL1 ? ctrl1_r :
                      busIn.addr == ADDR_CTRL2 ? ctrl2_r :
                      busIn.addr == ADDR_RXEXT ? rxExt_r :
                      busIn.addr == ADDR_TXEXT ? txExt_r : 8'h00;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl2_r <= RST_CTRL;
         ctrl1_r <= RST_CTRL;
         baud_r <= RST_BAUD;
         rxExt_r <= RST_EXT;
         txExt_r <= RST_EXT;
         {txEmpty_r, txDone_r} <= RST_STATUS[7:6];
         {rxFull_r, idle_r, overrun_r, frameErr_r} <= 4'h0;
         statusSeen_r <= 1'b0;
         txEverOn_r <= 1'b0;
         txOnPrev_r <= 1'b0;
         brkPrev_r <= 1'b0;
         preamblePend_r <= 1'b0;
         brkPend_r <= 1'b0;
         idleArmed_r <= 1'b0;
         txBuf_r <= 8'h00;
         rxBuf_r <= 8'h00;
         rdData_r <= 8'h00;
      end else begin
         rdData_r <= busIn.rd ? rdMux : 8'h00;
         if (busIn.wr) begin
            case (busIn.addr)
               ADDR_DATA: txBuf_r <= busIn.wdata;
               ADDR_BAUD: baud_r <= busIn.wdata;
               ADDR_CTRL1: ctrl1_r <= busIn.wdata;
               ADDR_CTRL2: ctrl2_r <= busIn.wdata;
               ADDR_RXEXT: rxExt_r <= busIn.wdata;
               ADDR_TXEXT: txExt_r <= busIn.wdata;
               default: ;
            endcase
         end
         if (wakeUp) begin
            ctrl2_r[CR2_MUTE] <= 1'b0;
         end
         if (rdStatus) begin
            statusSeen_r <= 1'b1;
         end else if (busIn.rd || busIn.wr) begin
            statusSeen_r <= busIn.addr == ADDR_STATUS;
         end
         txOnPrev_r <= txOn;
         brkPrev_r <= ctrl2_r[CR2_BRK];
         if (txOn) begin
            txEverOn_r <= 1'b1;
         end
         // Pulse on enable during a frame queues a preamble
         if (txRise && txState_r != TX_IDLE) begin
            preamblePend_r <= 1'b1;
         end else if (startPre) begin
            preamblePend_r <= 1'b0;
         end
         if (brkFall) begin
            brkPend_r <= 1'b1;
         end else if (startBrk) begin
            brkPend_r <= 1'b0;
         end
         // Set wins over the software clear
         txEmpty_r <= txLoad | (txEmpty_r & !flagClrTx);
         txDone_r <= (txFrameEnd && txKind_r == 2'h0) | (txDone_r & !flagClrTx);
         if (rxDeliver) begin
            if (rxFull_r && !flagClrRx) begin
               overrun_r <= 1'b1;
            end else begin
               rxBuf_r <= rxWord[7:0];
               rxFull_r <= 1'b1;
               frameErr_r <= !rxSync2_r;
               ctrl1_r[7] <= rxWord[8];
               idleArmed_r <= 1'b1;
            end
         end else if (flagClrRx) begin
            {rxFull_r, overrun_r, frameErr_r} <= 3'h0;
         end
         // Idle only rearms after a fresh word
         if (idleSeen && idleArmed_r && !muted) begin
            idle_r <= 1'b1;
            idleArmed_r <= 1'b0;
         end else if (flagClrRx) begin
            idle_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Outputs
   assign rdData = rdData_r;
   assign txdOut = txLine_r;
   assign txdOe_n = !(txOn || rxOn) && txEverOn_r ? 1'b1 : !txEverOn_r;
   assign irqReq = (ctrl2_r[CR2_TXEIE] && txEmpty_r)
                 || (ctrl2_r[CR2_XMIT_DONE_IRQ_ON] && txDone_r)
                 || (ctrl2_r[CR2_RXIE] && (overrun_r || rxFull_r))
                 || (ctrl2_r[CR2_IDIE] && idle_r);
endmodule

/* tb/sercb_remote.sv */
// Remote serial transceiver model facing the core's line pins.
// Assumes 8N1 frames, LSB first, line idle high; bitClk set by the bench.
module sercb_remote (
   input wire logic clk,
   input wire logic lineIn,
   output logic lineOut
);
   timeunit 1ns;
   timeprecision 1ps;
   int bitClk = 16;
   int rxCount = 0;
   logic [7:0] rxByte = 8'h00;
   logic rxStop = 1'b1;
   initial lineOut = 1'b1;
   // ==========================================
   // Receive: sample mid-bit, so small phase error is tolerated
   always begin
      @(negedge lineIn);
      repeat (bitClk / 2) @(posedge clk);
      if (lineIn == 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (bitClk) @(posedge clk);
            rxByte[i] = lineIn;
         end
         repeat (bitClk) @(posedge clk);
         rxStop = lineIn;
         rxCount++;
      end
   end
   // ==========================================
   // Send one frame toward the core
   task automatic sendByte(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         lineOut <= f[i];
         repeat (bitClk - 1) @(posedge clk);
      end
   endtask
endmodule

/* tb/sercb_core_chk.sv */
// Port checker for the serial control core, bound to every instance.
// Assumes registers change only through busIn writes, apart from the mute bit and bit 7 of control one.
module sercb_core_chk import sercb_pkg::*; (
   input wire logic clk,
   input wire logic resetn,
   input wire sercb_bus_t busIn,
   input wire logic [7:0] rdData,
   input wire logic txdOut,
   input wire logic txdOe_n,
   input wire logic rxdIn,
   input wire logic irqReq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctrl_r;
   logic [7:0] baud_r;
   logic teEver_r;
   logic dataWr_r;
   wire ctrlWr = busIn.wr && busIn.addr == ADDR_CTRL2;
   wire baudWr = busIn.wr && busIn.addr == ADDR_BAUD;
   wire dataWr = busIn.wr && busIn.addr == ADDR_DATA;
   // ==========================================
   // Shadow state; mute bit is ignored since hardware may drop it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= RST_CTRL;
         baud_r <= RST_BAUD;
         teEver_r <= 1'b0;
         dataWr_r <= 1'b0;
      end else begin
         ctrl_r <= ctrlWr ? busIn.wdata : ctrl_r;
         baud_r <= baudWr ? busIn.wdata : baud_r;
         teEver_r <= teEver_r | ctrl_r[CR2_TXON];
         dataWr_r <= dataWr_r | dataWr;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   a_irq_all_off: assert property (ctrl_r[7:4] == 4'h0 |-> !irqReq)
      else $error("irq without any enable");
   a_irq_tx_empty: assert property (ctrl_r[CR2_TXEIE] && !dataWr_r |-> irqReq)
      else $error("tx empty irq missing");
   a_irq_tx_done: assert property (ctrl_r[CR2_XMIT_DONE_IRQ_ON] && !dataWr_r |-> irqReq)
      else $error("tx done irq missing");
   a_pin_kept_free: assert property (!teEver_r && !ctrl_r[CR2_TXON] |-> txdOe_n)
      else $error("pin taken before tx enable");
   a_pin_driven: assert property (teEver_r && ctrl_r[CR2_TXON] |-> !txdOe_n)
      else $error("pin not driven while tx on");
   a_line_idle: assert property (!teEver_r && !ctrl_r[CR2_TXON] |-> txdOut)
      else $error("line moved while tx off");
   a_start_delay: assert property ($rose(ctrl_r[CR2_TXON]) && !teEver_r
      |-> txdOut [*8] ##1 txdOut [*8])
      else $error("frame began within a bit time");
   a_ctrl_readback: assert property (busIn.rd && busIn.addr == ADDR_CTRL2
      |=> rdData[7:2] == ctrl_r[7:2])
      else $error("control readback wrong");
   a_baud_readback: assert property (busIn.rd && busIn.addr == ADDR_BAUD
      |=> rdData == baud_r)
      else $error("baud readback wrong");
   a_unmapped_zero: assert property (busIn.rd && busIn.addr == 3'h6 |=> rdData == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind sercb_core sercb_core_chk i_chk (.clk(clk), .resetn(resetn), .busIn(busIn),
   .rdData(rdData), .txdOut(txdOut), .txdOe_n(txdOe_n), .rxdIn(rxdIn), .irqReq(irqReq));

/* tb/test_sercb_core.sv */
// Self-checking bench for the serial control core.
// Assumes the remote model on the line and the bound port checker.
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_sercb_core import sercb_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   sercb_bus_t busIn = '0;
   logic [7:0] rdData;
   logic txdOut;
   logic txdOe_n;
   logic rxdIn;
   logic irqReq;
   logic [7:0] rd;
   int miscompares = 0;
   int tests_run = 0;
   always #2.5 clk = ~clk;
   sercb_core i_dut (.clk(clk), .resetn(resetn), .busIn(busIn), .rdData(rdData),
      .txdOut(txdOut), .txdOe_n(txdOe_n), .rxdIn(rxdIn), .irqReq(irqReq));
   sercb_remote i_remote (.clk(clk), .lineIn(txdOut), .lineOut(rxdIn));
   // ==========================================
   // Register port
   task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      busIn <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busIn.wr <= 1'b0;
   endtask
   task automatic rdReg(input logic [2:0] a);
      @(posedge clk);
      busIn <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busIn.rd <= 1'b0;
      #1 rd = rdData;
   endtask
   task automatic waitFrame(input int n);
      for (int k = 0; k < 30000 && i_remote.rxCount < n; k++) @(posedge clk);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      logic [2:0] r [5] = '{ADDR_CTRL2, ADDR_BAUD, ADDR_RXEXT, ADDR_TXEXT, 3'h6};
      foreach (r[i]) begin
         rdReg(r[i]);
         `CHK(rd, 8'h00)
         wrReg(r[i], 8'hA4);
         rdReg(r[i]);
         `CHK(rd, (i == 4) ? 8'h00 : 8'hA4)
         wrReg(r[i], 8'h00);
      end
      rdReg(ADDR_STATUS);
      `CHK(rd, RST_STATUS)
      `CHK(txdOe_n, 1'b1)
   endtask
   task automatic t_irq;
      logic [7:0] ie [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h00};
      foreach (ie[i]) begin
         wrReg(ADDR_CTRL2, ie[i]);
         @(posedge clk);
         #1;
         `CHK(irqReq, ie[i][7] | ie[i][6])
      end
   endtask
   task automatic t_tx;
      logic [7:0] br [5] = '{8'h40, 8'h80, 8'hC0, 8'h38, 8'h00};
      logic [7:0] ex [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
      int bc [5] = '{48, 64, 208, 2048, 32};
      wrReg(ADDR_CTRL2, 8'h08);
      @(posedge clk);
      #1;
      `CHK(txdOe_n, 1'b0)
      foreach (br[i]) begin
         wrReg(ADDR_BAUD, br[i]);
         wrReg(ADDR_TXEXT, ex[i]);
         i_remote.bitClk = bc[i];
         rdReg(ADDR_STATUS);
         wrReg(ADDR_DATA, 8'h5A + 8'(i));
         waitFrame(i + 1);
         `CHK(i_remote.rxByte, 8'h5A + 8'(i))
      end
      // Remote counts at mid stop bit; let the stop bit finish
      repeat (32) @(posedge clk);
      rdReg(ADDR_STATUS);
      `CHK(rd[7:6], 2'b11)
      wrReg(ADDR_TXEXT, 8'h00);
      i_remote.bitClk = 16;
   endtask
   task automatic t_rx;
      wrReg(ADDR_CTRL2, 8'h2C);
      i_remote.sendByte(8'hC3);
      for (int k = 0; k < 100 && irqReq !== 1'b1; k++) @(posedge clk);
      `CHK(irqReq, 1'b1)
      rdReg(ADDR_STATUS);
      rdReg(ADDR_DATA);
      `CHK(rd, 8'hC3)
      @(posedge clk);
      #1;
      `CHK(irqReq, 1'b0)
      // Mute now; wake on idle needs the idle count, restarted by that word's low bits, to reach lastBit + 2 while muted
      wrReg(ADDR_CTRL2, 8'h2E);
      rdReg(ADDR_CTRL2);
      `CHK(rd[1], 1'b1)
      // Idle line after that word wakes the receiver
      repeat (200) @(posedge clk);
      rdReg(ADDR_CTRL2);
      `CHK(rd[1], 1'b0)
   endtask
   task automatic t_pre;
      int n;
      rdReg(ADDR_STATUS);
      wrReg(ADDR_DATA, 8'h3C);
      for (n = 0; n < 100 && txdOut !== 1'b0; n++) @(posedge clk);
      // Enable pulse while the word is on the line queues an idle frame
      wrReg(ADDR_CTRL2, 8'h00);
      wrReg(ADDR_CTRL2, 8'h08);
      rdReg(ADDR_STATUS);
      wrReg(ADDR_DATA, 8'h96);
      waitFrame(6);
      `CHK(i_remote.rxByte, 8'h3C)
      for (n = 0; n < 400 && txdOut !== 1'b0; n++) @(posedge clk);
      `CHK(n > 150, 1'b1)
      waitFrame(7);
      `CHK(i_remote.rxByte, 8'h96)
   endtask
   task automatic t_break;
      wrReg(ADDR_CTRL2, 8'h09);
      wrReg(ADDR_CTRL2, 8'h08);
      waitFrame(8);
      `CHK({i_remote.rxByte, i_remote.rxStop}, 9'h000)
   endtask
   // ==========================================
   task automatic summarize;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_irq;
      t_tx;
      t_rx;
      t_pre;
      t_break;
      summarize;
   end
   // Frames need about 28k cycles in all
   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      summarize;
   end
endmodule
